//--- hw/bridge_consts.svh
// register offsets, field positions, reset values and encodings of the
// bridge output stage; assumes a byte-wide register port with 3-bit address
`ifndef BRIDGE_CONSTS_SVH
`define BRIDGE_CONSTS_SVH

`define ADDR_CTRL      3'h0
`define ADDR_DEADBAND  3'h1
`define ADDR_SHUTDOWN  3'h2
`define ADDR_FLAGS     3'h3
`define ADDR_PINDIR    3'h4

`define MODE_SINGLE    2'h0
`define MODE_HALF      2'h2
`define MODE_FWD       2'h1
`define MODE_REV       2'h3

`define CTRL_MODE_HI   7
`define CTRL_MODE_LO   6
`define CTRL_EN_BIT    2
`define CTRL_POL_AC    0
`define CTRL_POL_BD    1

`define SD_STATUS_BIT  7
`define SD_SRC_HI      6
`define SD_SRC_LO      4
`define SD_AC_HI       3
`define SD_AC_LO       2
`define SD_BD_HI       1
`define SD_BD_LO       0
`define SRC_CMP1_BIT   0
`define SRC_CMP2_BIT   1
`define SRC_PIN_BIT    2
`define PSS_TRI_BIT    1
`define PSS_LVL_BIT    0

`define FLAG_PERIOD    0

`define CTRL_RST       8'h00
`define DB_RST         7'h00
`define SD_RST         8'h00
`define PINDIR_RST     4'hF
`define DB_SAT         7'h7F

`endif

//--- hw/bridge_pkg.sv
// types shared by the bridge output stage
// assumes the constants header is compiled alongside
package bridge_pkg;
  typedef enum logic [1:0] {
    single_out,
    half_bridge,
    full_fwd,
    full_rev
  } bridge_mode_e;

  typedef logic [7:0] reg_byte_t;
endpackage : bridge_pkg

//--- hw/enhanced_pwm_bridge_shutdown.sv
// output steering, dead band, polarity and auto-shutdown of a pwm unit
// assumes pwm_wave and a one-cycle period_start pulse from the timer,
// all inputs synchronous to ref_clk
//
// How it works
// (RULE1) mode field 00 single, 10 half, 01 forward, 11 reverse
// (RULE2) half bridge: wave on a, complement on b, c and d unused
// (RULE3) half bridge: outputs wait the dead-band count before going active
// (RULE4) dead band longer than the pulse keeps that output inactive
// (RULE5) forward: a active, d modulated, b and c inactive
// (RULE6) reverse: c active, b modulated, a and d inactive
// (RULE7) a direction toggle takes effect from the next pwm period
// (RULE8) on toggle: modulated outputs off, unmodulated swap, resume next period
// (RULE9) full bridge uses no dead band
// (RULE10) software lowers duty one period before reversing near full duty
// (RULE11) polarity field picks active level of pair a/c and pair b/d
// (RULE12) software sets polarity before enabling drivers, never while enabled
// (RULE13) software lets one full period run before enabling drivers
// (RULE14) period flag is set as the second pwm period begins
// (RULE15) software clears direction bits of every pin the mode uses
// (RULE16) shutdown from low pin, either comparator, or software set
// (RULE17) status bit zero is normal, one is shutdown state
// (RULE18) status bit stays set until software clears it
// (RULE19) shutdown forces enabled pins at once, without a clock edge
// (RULE20) each pair has its own shutdown level: high, low or released
// (RULE21) pair field 00 low, 01 high, 1x high impedance
// (RULE22) after clearing, modulation resumes at the next period start
//
// The strobed register port and the register offsets are this design's own decisions.
`timescale 1ns/100ps
`include "bridge_consts.svh"

module enhanced_pwm_bridge_shutdown (
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst,
  // register port
  input  wire logic [2:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // timer waveform
  input  wire logic       pwm_wave,
  input  wire logic       period_start,
  // shutdown sources
  input  wire logic       ext_shutdown_n,
  input  wire logic       comparator_one,
  input  wire logic       comparator_two,
  // output pins
  output logic            bridge_out_a,
  output logic            bridge_out_b,
  output logic            bridge_out_c,
  output logic            bridge_out_d,
  output logic            bridge_oe_n_a,
  output logic            bridge_oe_n_b,
  output logic            bridge_oe_n_c,
  output logic            bridge_oe_n_d
);

  ////////////////////////////////////////////////////////////////////////
  // state
  logic [1:0]          output_mode_field_q;
  logic                pwm_en_q;
  logic [1:0]          polarity_field_q;
  logic [6:0]          deadband_count_q;
  logic                shutdown_status_bit_q;
  logic [2:0]          shutdown_source_select_q;
  logic [1:0]          pair_ac_shutdown_state_q;
  logic [1:0]          pair_bd_shutdown_state_q;
  logic                period_match_flag_q;
  logic [3:0]          port_direction_bits_q;
  logic                running_q;
  logic                dir_applied_q;
  logic                hold_q;
  logic                wave_prev_q;
  logic [6:0]          elapsed_q;
  logic [3:0]          level_q;
  bridge_pkg::reg_byte_t rdata_q;

  logic                wr_ctrl;
  logic                wr_sd;
  logic                wr_flags;
  bridge_pkg::bridge_mode_e mode;
  logic                full_mode;
  logic                dir_req;
  logic                dir_pending;
  logic                wave_g;
  logic                wave_edge;
  logic                db_ok;
  logic                sd_event;
  logic                force_sd;
  logic [3:0]          act;
  logic [3:0]          pol;
  logic [3:0]          pss_tri;
  logic [3:0]          pss_lvl;
  logic [3:0]          drive;
  bridge_pkg::reg_byte_t rd_mux;
  assign wr_ctrl  = reg_wr && (reg_addr == `ADDR_CTRL);
  assign wr_sd    = reg_wr && (reg_addr == `ADDR_SHUTDOWN);
  assign wr_flags = reg_wr && (reg_addr == `ADDR_FLAGS);
  ////////////////////////////////////////////////////////////////////////
  // mode decode
  always_comb begin
    case (output_mode_field_q)
      `MODE_SINGLE: mode = bridge_pkg::single_out;   // see (RULE1)
      `MODE_HALF:   mode = bridge_pkg::half_bridge;  // see (RULE1)
      `MODE_FWD:    mode = bridge_pkg::full_fwd;     // see (RULE1)
      `MODE_REV:    mode = bridge_pkg::full_rev;     // see (RULE1)
      default:      mode = bridge_pkg::single_out;
    endcase
  end
  assign full_mode = (mode == bridge_pkg::full_fwd) ||
                     (mode == bridge_pkg::full_rev);
  // the upper mode bit doubles as the direction select in full bridge
  assign dir_req     = output_mode_field_q[1];
  assign dir_pending = full_mode && (dir_req != dir_applied_q);
  ////////////////////////////////////////////////////////////////////////
  // configuration registers
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      output_mode_field_q <= 2'(`CTRL_RST >> `CTRL_MODE_LO);
      pwm_en_q            <= 1'b0;
      polarity_field_q    <= 2'h0;
    end else if (wr_ctrl) begin
      output_mode_field_q <= reg_wdata[`CTRL_MODE_HI:`CTRL_MODE_LO];
      pwm_en_q            <= reg_wdata[`CTRL_EN_BIT];
      polarity_field_q    <= reg_wdata[`CTRL_POL_BD:`CTRL_POL_AC];
    end
  end
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      deadband_count_q <= `DB_RST;
    end else if (reg_wr && (reg_addr == `ADDR_DEADBAND)) begin
      deadband_count_q <= reg_wdata[6:0];
    end
  end
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      shutdown_source_select_q <= 3'h0;
      pair_ac_shutdown_state_q <= 2'h0;
      pair_bd_shutdown_state_q <= 2'h0;
    end else if (wr_sd) begin
      shutdown_source_select_q <= reg_wdata[`SD_SRC_HI:`SD_SRC_LO];
      pair_ac_shutdown_state_q <= reg_wdata[`SD_AC_HI:`SD_AC_LO];
      pair_bd_shutdown_state_q <= reg_wdata[`SD_BD_HI:`SD_BD_LO];
    end
  end
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      port_direction_bits_q <= `PINDIR_RST;
    end else if (reg_wr && (reg_addr == `ADDR_PINDIR)) begin
      port_direction_bits_q <= reg_wdata[3:0];
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // shutdown
  // each select bit adds one source, so the eight codes fall out as an or
  assign sd_event =
    (shutdown_source_select_q[`SRC_PIN_BIT]  && !ext_shutdown_n) ||
    (shutdown_source_select_q[`SRC_CMP1_BIT] && comparator_one)  ||
    (shutdown_source_select_q[`SRC_CMP2_BIT] && comparator_two); // see (RULE16)

  // an event in the clearing cycle keeps the bit set
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      shutdown_status_bit_q <= 1'(`SD_RST >> `SD_STATUS_BIT);
    end else begin
      shutdown_status_bit_q <= sd_event ||
        (wr_sd ? reg_wdata[`SD_STATUS_BIT]
               : shutdown_status_bit_q); // see (RULE18) see (RULE16)
    end
  end
  // pins stay parked until a fresh period starts after the clear
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      hold_q <= 1'b0;
    end else if (sd_event || shutdown_status_bit_q) begin
      hold_q <= 1'b1;
    end else if (period_start) begin
      hold_q <= 1'b0; // see (RULE22)
    end
  end
  // combinational path so the pins react without waiting for an edge
  assign force_sd = sd_event || shutdown_status_bit_q || hold_q; // see (RULE19)
  ////////////////////////////////////////////////////////////////////////
  // period tracking
  // output starts only at a period boundary to avoid a partial first pulse
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      running_q <= 1'b0;
    end else if (!pwm_en_q) begin
      running_q <= 1'b0;
    end else if (period_start) begin
      running_q <= 1'b1;
    end
  end
  // first boundary starts output, so the flag marks the second one
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      period_match_flag_q <= 1'b0;
    end else if (period_start && running_q && pwm_en_q) begin
      period_match_flag_q <= 1'b1; // see (RULE14)
    end else if (wr_flags && reg_wdata[`FLAG_PERIOD]) begin
      period_match_flag_q <= 1'b0;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      dir_applied_q <= 1'b0;
    end else if (!full_mode || period_start) begin
      dir_applied_q <= dir_req; // see (RULE7)
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // dead band
  assign wave_g    = pwm_wave && running_q;
  assign wave_edge = wave_g != wave_prev_q;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wave_prev_q <= 1'b0;
      elapsed_q   <= 7'h00;
    end else begin
      wave_prev_q <= wave_g;
      if (wave_edge) begin
        elapsed_q <= 7'h00;
      end else if (elapsed_q != `DB_SAT) begin
        elapsed_q <= elapsed_q + 7'h01;
      end
    end
  end

  // a pulse shorter than the count ends before db_ok rises
  assign db_ok = wave_edge ? (deadband_count_q == 7'h00)
               : ({1'b0, elapsed_q} + 8'h01 >=
                  {1'b0, deadband_count_q}); // see (RULE3) see (RULE4)

  ////////////////////////////////////////////////////////////////////////
  // steering, index 0..3 is a..d
  always_comb begin
    act = 4'h0;
    case (mode)
      bridge_pkg::single_out: begin
        act[0] = wave_g;
      end
      bridge_pkg::half_bridge: begin
        act[0] = wave_g && db_ok;  // see (RULE2) see (RULE3)
        act[1] = !wave_g && db_ok && running_q; // see (RULE2)
      end
      bridge_pkg::full_fwd, bridge_pkg::full_rev: begin
        // dead band deliberately absent here
        act[0] = running_q && !dir_req; // see (RULE5) see (RULE8)
        act[2] = running_q && dir_req;  // see (RULE6) see (RULE8)
        act[3] = wave_g && !dir_pending &&
                 !dir_applied_q; // see (RULE5) see (RULE9)
        act[1] = wave_g && !dir_pending &&
                 dir_applied_q;  // see (RULE6) see (RULE8)
      end
      default: begin
        act = 4'h0;
      end
    endcase
  end

  assign pol = {polarity_field_q[1], polarity_field_q[0],
                polarity_field_q[1], polarity_field_q[0]};

  // changing polarity live glitches the pins; software must avoid it
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      level_q <= 4'h0;
    end else begin
      level_q <= act ^ pol; // see (RULE11)
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // pins
  assign pss_tri = {pair_bd_shutdown_state_q[`PSS_TRI_BIT],
                    pair_ac_shutdown_state_q[`PSS_TRI_BIT],
                    pair_bd_shutdown_state_q[`PSS_TRI_BIT],
                    pair_ac_shutdown_state_q[`PSS_TRI_BIT]}; // see (RULE20)
  assign pss_lvl = {pair_bd_shutdown_state_q[`PSS_LVL_BIT],
                    pair_ac_shutdown_state_q[`PSS_LVL_BIT],
                    pair_bd_shutdown_state_q[`PSS_LVL_BIT],
                    pair_ac_shutdown_state_q[`PSS_LVL_BIT]}; // see (RULE21)

  assign drive = ~port_direction_bits_q & {4{pwm_en_q}};

  assign bridge_out_a = force_sd ? pss_lvl[0] : level_q[0]; // see (RULE19)
  assign bridge_out_b = force_sd ? pss_lvl[1] : level_q[1]; // see (RULE19)
  assign bridge_out_c = force_sd ? pss_lvl[2] : level_q[2]; // see (RULE19)
  assign bridge_out_d = force_sd ? pss_lvl[3] : level_q[3]; // see (RULE19)

  assign bridge_oe_n_a = !drive[0] || (force_sd && pss_tri[0]); // see (RULE21)
  assign bridge_oe_n_b = !drive[1] || (force_sd && pss_tri[1]); // see (RULE21)
  assign bridge_oe_n_c = !drive[2] || (force_sd && pss_tri[2]); // see (RULE21)
  assign bridge_oe_n_d = !drive[3] || (force_sd && pss_tri[3]); // see (RULE21)

  ////////////////////////////////////////////////////////////////////////
  // read back
  always_comb begin
    rd_mux = 8'h00;
    case (reg_addr)
      `ADDR_CTRL: begin
        rd_mux[`CTRL_MODE_HI:`CTRL_MODE_LO] = output_mode_field_q;
        rd_mux[`CTRL_EN_BIT]               = pwm_en_q;
        rd_mux[`CTRL_POL_BD:`CTRL_POL_AC]  = polarity_field_q;
      end
      `ADDR_DEADBAND: begin
        rd_mux[6:0] = deadband_count_q;
      end
      `ADDR_SHUTDOWN: begin
        rd_mux[`SD_STATUS_BIT]       = shutdown_status_bit_q; // see (RULE17)
        rd_mux[`SD_SRC_HI:`SD_SRC_LO] = shutdown_source_select_q;
        rd_mux[`SD_AC_HI:`SD_AC_LO]   = pair_ac_shutdown_state_q;
        rd_mux[`SD_BD_HI:`SD_BD_LO]   = pair_bd_shutdown_state_q;
      end
      `ADDR_FLAGS: begin
        rd_mux[`FLAG_PERIOD] = period_match_flag_q;
        rd_mux[1]            = running_q;
        rd_mux[2]            = dir_applied_q;
        rd_mux[3]            = dir_pending;
        rd_mux[4]            = force_sd;
      end
      `ADDR_PINDIR: begin
        rd_mux[3:0] = port_direction_bits_q;
      end
      default: begin
        rd_mux = 8'h00;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= reg_rd ? rd_mux : 8'h00;
    end
  end

  assign reg_rdata = rdata_q;

endmodule : enhanced_pwm_bridge_shutdown

//--- testbench/bridge_asserts.sv
// port checks of the bridge output stage, bound onto the top module
// assumes configuration changes only through register writes
`timescale 1ns/100ps
`include "bridge_consts.svh"
module bridge_checker (
  // clock and reset
  input wire logic       ref_clk,
  input wire logic       rst,
  // register writes
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  // waveform and shutdown sources
  input wire logic       pwm_wave,
  input wire logic       ext_shutdown_n,
  input wire logic       comparator_one,
  input wire logic       comparator_two,
  // pins
  input wire logic       bridge_out_a,
  input wire logic       bridge_out_b,
  input wire logic       bridge_out_c,
  input wire logic       bridge_out_d,
  input wire logic       bridge_oe_n_a,
  input wire logic       bridge_oe_n_d
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic [7:0] ctrl_q;
  logic [7:0] sd_q;
  logic [6:0] db_q;
  logic [6:0] hi_q;
  logic [6:0] lo_q;
  logic [5:0] age_q;
  logic [3:0] pd_q;
  logic [1:0] md;
  logic       en;
  logic       pa;
  logic       pb;
  logic       calm;
  logic       hit;
  //////////////////////////////////////////////////////////////////////////
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ctrl_q <= 8'h00;
      sd_q   <= 8'h00;
      db_q   <= 7'h00;
      pd_q   <= 4'hF;
    end else if (reg_wr) begin
      if (reg_addr == `ADDR_CTRL) ctrl_q <= reg_wdata;
      if (reg_addr == `ADDR_SHUTDOWN) sd_q <= reg_wdata;
      if (reg_addr == `ADDR_DEADBAND) db_q <= reg_wdata[6:0];
      if (reg_addr == `ADDR_PINDIR) pd_q <= reg_wdata[3:0];
    end
  end
  // a settling time of two periods keeps start-up and pending turns out
  always_ff @(posedge ref_clk) begin
    if (rst || (reg_wr && reg_addr inside {`ADDR_CTRL, `ADDR_SHUTDOWN}))
      age_q <= 6'h00;
    else if (age_q != 6'h3F)
      age_q <= age_q + 6'h01;
  end
  always_ff @(posedge ref_clk) begin
    if (rst || !pwm_wave) hi_q <= 7'h00;
    else if (hi_q != 7'h7F) hi_q <= hi_q + 7'h01;
    if (rst || pwm_wave) lo_q <= 7'h00;
    else if (lo_q != 7'h7F) lo_q <= lo_q + 7'h01;
  end
  assign md = ctrl_q[`CTRL_MODE_HI:`CTRL_MODE_LO];
  assign en = ctrl_q[`CTRL_EN_BIT];
  assign pa = ctrl_q[`CTRL_POL_AC];
  assign pb = ctrl_q[`CTRL_POL_BD];
  assign calm = en && age_q > 6'h2C && sd_q == 8'h00 && ext_shutdown_n
                && !comparator_one && !comparator_two;
  assign hit = (sd_q[4] && comparator_one) || (sd_q[5] && comparator_two)
               || (sd_q[6] && !ext_shutdown_n);
  //////////////////////////////////////////////////////////////////////////
  a_half_a_wait: assert property (calm && md == `MODE_HALF &&
    bridge_out_a != pa |-> hi_q > db_q || $past(hi_q) > db_q)
    else $error("half bridge a went active before its dead band");
  a_half_b_wait: assert property (calm && md == `MODE_HALF &&
    bridge_out_b != pb |-> lo_q > db_q || $past(lo_q) > db_q)
    else $error("half bridge b active outside complement pulse");
  a_half_cd_idle: assert property (calm && md == `MODE_HALF |->
    bridge_out_c == pa && bridge_out_d == pb)
    else $error("half bridge c or d not inactive");
  a_fwd_static: assert property (calm && md == `MODE_FWD |->
    bridge_out_a != pa && bridge_out_b == pb && bridge_out_c == pa)
    else $error("forward static pins wrong");
  a_rev_static: assert property (calm && md == `MODE_REV |->
    bridge_out_a == pa && bridge_out_d == pb && bridge_out_c != pa)
    else $error("reverse static pins wrong");
  a_fwd_no_db: assert property (calm && md == `MODE_FWD && $past(calm)
    |-> bridge_out_d == ($past(pwm_wave) ^ pb))
    else $error("forward d does not follow waveform next cycle");
  a_single_only_a: assert property (calm && md == `MODE_SINGLE &&
    $past(calm) |-> bridge_out_a == ($past(pwm_wave) ^ pa) && bridge_out_b == pb)
    else $error("single mode pins wrong");
  a_force_ac: assert property (hit && en && !pd_q[0] |-> (sd_q[3] ?
    bridge_oe_n_a : (!bridge_oe_n_a && bridge_out_a == sd_q[2])))
    else $error("pair a c not forced to its shutdown state");
  a_force_bd: assert property (hit && en && !pd_q[3] |-> (sd_q[1] ?
    bridge_oe_n_d : (!bridge_oe_n_d && bridge_out_d == sd_q[0])))
    else $error("pair b d not forced to its shutdown state");
  c_half: cover property (calm && md == `MODE_HALF);
  c_rev: cover property (calm && md == `MODE_REV);
  c_forced: cover property (hit && en && !pd_q[0]);
endmodule : bridge_checker

bind enhanced_pwm_bridge_shutdown bridge_checker u_chk (
  .ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .pwm_wave(pwm_wave),
  .ext_shutdown_n(ext_shutdown_n), .comparator_one(comparator_one),
  .comparator_two(comparator_two), .bridge_out_a(bridge_out_a),
  .bridge_out_b(bridge_out_b), .bridge_out_c(bridge_out_c),
  .bridge_out_d(bridge_out_d), .bridge_oe_n_a(bridge_oe_n_a),
  .bridge_oe_n_d(bridge_oe_n_d)
);

//--- testbench/bridge_load.sv
// power switch drivers on the four pins, with pull-downs on each line
// assumes pins released by a high enable; counts high cycles per line
`timescale 1ns/100ps
module bridge_load (
  // clock and counter control
  input  wire logic       ref_clk,
  input  wire logic       cnt_clr,
  input  wire logic       cnt_en,
  // pins
  input  wire logic [3:0] pin_out,
  input  wire logic [3:0] pin_oe_n,
  // observed line levels
  output logic [3:0]      lvl,
  output logic [3:0][7:0] hi_cnt
);
  // a released line falls to its pull-down, so switches stay off
  assign lvl = pin_out & ~pin_oe_n;
  always_ff @(posedge ref_clk) begin
    for (int i = 0; i < 4; i++) begin
      if (cnt_clr) hi_cnt[i] <= 8'h00;
      else if (cnt_en) hi_cnt[i] <= hi_cnt[i] + {7'h00, lvl[i]};
    end
  end
endmodule : bridge_load

//--- testbench/tb_enhanced_pwm_bridge_shutdown.sv
// self-checking bench: timer waveform, register port, shutdown sources
// assumes a 20-cycle period and registers as laid out in the constants
`timescale 1ns/100ps
`include "bridge_consts.svh"
module tb_enhanced_pwm_bridge_shutdown;
  localparam int PER = 20;
  logic ref_clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00, reg_rdata, rdv;
  logic pwm_wave = 1'b0, period_start = 1'b0, ext_shutdown_n = 1'b1;
  logic comparator_one = 1'b0, comparator_two = 1'b0;
  logic cnt_clr = 1'b0, cnt_en = 1'b0;
  logic [3:0] po, oe, lvl;
  logic [3:0][7:0] hi;
  int n_errors = 0, n_compared = 0, cyc = 0, ph = 0, n_ps = 0;
  int duty = 10, db = 2;
  always #25 ref_clk = ~ref_clk;
  //////////////////////////////////////////////////////////////////////////
  always @(posedge ref_clk) begin
    ph <= (ph + 1) % PER;
    period_start <= ((ph + 1) % PER) == 0;
    pwm_wave <= ((ph + 1) % PER) < duty;
    if (period_start) n_ps <= n_ps + 1;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      wrap_up();
    end
  end
  enhanced_pwm_bridge_shutdown DUT (
    .ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .pwm_wave(pwm_wave), .period_start(period_start),
    .ext_shutdown_n(ext_shutdown_n), .comparator_one(comparator_one),
    .comparator_two(comparator_two), .bridge_out_a(po[0]),
    .bridge_out_b(po[1]), .bridge_out_c(po[2]), .bridge_out_d(po[3]),
    .bridge_oe_n_a(oe[0]), .bridge_oe_n_b(oe[1]), .bridge_oe_n_c(oe[2]),
    .bridge_oe_n_d(oe[3]));
  bridge_load u_load (.ref_clk(ref_clk), .cnt_clr(cnt_clr), .cnt_en(cnt_en),
    .pin_out(po), .pin_oe_n(oe), .lvl(lvl), .hi_cnt(hi));
  //////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [7:0] got, exp, input string what);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : check
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd
  task automatic wait_ps(input int k);
    int n0;
    @(posedge ref_clk);
    n0 = n_ps;
    while (n_ps < n0 + k) @(posedge ref_clk);
    repeat (2) @(posedge ref_clk);
  endtask : wait_ps
  task automatic reset_test;
    rd(`ADDR_CTRL, rdv); check(rdv, `CTRL_RST, "ctrl reset");
    rd(`ADDR_SHUTDOWN, rdv); check(rdv, `SD_RST, "shutdown reset");
    rd(`ADDR_PINDIR, rdv); check(rdv, 8'h0F, "pin direction reset");
    rd(3'h5, rdv); check(rdv, 8'h00, "unmapped read");
    check({4'h0, oe}, 8'h0F, "pins released");
    $display("test reset done");
  endtask : reset_test
  task automatic setup(input logic [1:0] m, pol);
    wr(`ADDR_PINDIR, 8'h0F);
    wr(`ADDR_CTRL, 8'h00);
    wr(`ADDR_DEADBAND, 8'(db));
    wr(`ADDR_FLAGS, 8'h01);
    wr(`ADDR_CTRL, {m, 3'h0, 1'b1, pol});
    wait_ps(1);
    rd(`ADDR_FLAGS, rdv); check(rdv & 8'h01, 8'h00, "flag after 1st");
    wait_ps(1);
    rd(`ADDR_FLAGS, rdv); check(rdv & 8'h01, 8'h01, "flag after 2nd");
    wr(`ADDR_PINDIR, 8'h00);
  endtask : setup
  // expected figures are active cycles per period of pins a, b, c, d
  task automatic run_mode(input logic [1:0] m, pol, input int ea, eb, ec, ed);
    int e[4];
    int x;
    e = '{ea, eb, ec, ed};
    setup(m, pol);
    wait_ps(1);
    cnt_clr <= 1'b1;
    @(posedge ref_clk);
    cnt_clr <= 1'b0;
    cnt_en <= 1'b1;
    repeat (3 * PER) @(posedge ref_clk);
    cnt_en <= 1'b0;
    #1;
    for (int i = 0; i < 4; i++) begin
      x = pol[i % 2] ? 3 * (PER - e[i]) : 3 * e[i];
      check(hi[i], 8'(x), "high cycles of a pin");
    end
    $display("test mode %b dead band %0d done", m, db);
  endtask : run_mode
  task automatic dir_change;
    int n0;
    duty = 4;
    wait_ps(1);
    repeat (4) @(posedge ref_clk);
    wr(`ADDR_CTRL, {`MODE_FWD, 3'h0, 1'b1, 2'h3});
    n0 = n_ps;
    @(posedge ref_clk);
    #1 check({4'h0, lvl}, 8'h0E, "turn pins");
    while (n_ps == n0) begin
      @(posedge ref_clk);
      #1 check({6'h00, lvl[3], lvl[1]}, 8'h03, "no modulation");
    end
    duty = 10;
    $display("test direction change done");
  endtask : dir_change
  task automatic shutdown_all;
    logic [7:0] sd;
    logic [1:0] ac, bd;
    for (int i = 0; i < 4; i++) begin
      ac = i[1:0];
      bd = ac + 2'h1;
      sd = {i == 3, (i < 3) ? 3'(1 << i) : 3'h0, ac, bd};
      wr(`ADDR_SHUTDOWN, sd & 8'h7F);
      if (i == 3) wr(`ADDR_SHUTDOWN, sd);
      else begin
        @(posedge ref_clk);
        comparator_one <= (i == 0);
        comparator_two <= (i == 1);
        ext_shutdown_n <= (i != 2);
      end
      #1 check({4'h0, oe}, {4'h0, bd[1], ac[1], bd[1], ac[1]}, "sd oe");
      check({4'h0, lvl}, {4'h0, ~bd[1] & bd[0], ~ac[1] & ac[0],
        ~bd[1] & bd[0], ~ac[1] & ac[0]}, "sd level");
      @(posedge ref_clk);
      comparator_one <= 1'b0;
      comparator_two <= 1'b0;
      ext_shutdown_n <= 1'b1;
      rd(`ADDR_SHUTDOWN, rdv); check(rdv & 8'h80, 8'h80, "status held");
      wr(`ADDR_SHUTDOWN, sd & 8'h7F);
      rd(`ADDR_SHUTDOWN, rdv); check(rdv & 8'h80, 8'h00, "status clear");
      wait_ps(1);
      check({oe, 1'b0, lvl[2:0]}, 8'h06, "resumed");
    end
    wr(`ADDR_SHUTDOWN, 8'h00);
    $display("test shutdown sources done");
  endtask : shutdown_all
  task automatic wrap_up;
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : wrap_up
  //////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    reset_test();
    run_mode(`MODE_SINGLE, 2'h0, 10, 0, 0, 0);
    run_mode(`MODE_HALF, 2'h0, 8, 8, 0, 0);
    db = 12;
    run_mode(`MODE_HALF, 2'h0, 0, 0, 0, 0);
    db = 2;
    run_mode(`MODE_FWD, 2'h3, PER, 0, 0, 10);
    run_mode(`MODE_REV, 2'h3, 0, 10, PER, 0);
    dir_change();
    shutdown_all();
    wrap_up();
  end
endmodule : tb_enhanced_pwm_bridge_shutdown
